// file: common/dctd_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef DCTD_REGS_SVH
`define DCTD_REGS_SVH
`define DCTD_OFF_CTRL 8'h00
`define DCTD_OFF_PRESET01 8'h04
`define DCTD_OFF_PRESET23 8'h08
`define DCTD_OFF_LIMITS 8'h0c
`define DCTD_OFF_STATUS 8'h10
`define DCTD_OFF_FREQ 8'h14
`define DCTD_OFF_IRQSTAT 8'h18
`define DCTD_OFF_IRQMASK 8'h1c
`define DCTD_OFF_REFIN 8'h20
`define DCTD_RST_PRESET01 32'h012c_00c8
`define DCTD_RST_PRESET23 32'h01f4_0190
`define DCTD_RST_LIMITS 32'h01f4_0000
`define DCTD_RST_CTRL 32'h0000_01f4
`define DCTD_STEP_NS 1000000
`define DCTD_CLK_NS 8
`define DCTD_STEP_CYC (`DCTD_STEP_NS / `DCTD_CLK_NS)
`define DCTD_IRQ_TRIP 0
`define DCTD_IRQ_INTERLOCK 1
`define DCTD_IRQ_RUNCHG 2
`define DCTD_IRQ_OVERRIDE 3
`endif

// file: common/dctd_pkg.sv
// types shared by the terminal decoder
package dctd_pkg;
  // frequency in units of 0.1 Hz, signed: negative means counterclockwise
  typedef logic signed [15:0] dctd_freq_t;
  typedef enum logic [1:0] {DCTD_SRC_TERM, DCTD_SRC_KEY1, DCTD_SRC_KEY2, DCTD_SRC_BUS} dctd_src_t;
  typedef struct packed {
    logic run;
    logic ccw;
    logic coast;
    logic trip;
  } dctd_cmd_t;
  typedef struct packed {
    logic [3:0] term;
    logic extFault;
    logic override;
    logic [3:0] modSwitch;
    logic modPresent;
  } dctd_pins_t;
endpackage

// file: design/dctd_sync.sv
// two-flop synchroniser for the terminal pins
`timescale 1ns/1ps
module dctd_sync #(
  parameter int WIDTH = 10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1_r;

  initial begin
    if (WIDTH < 1) begin
      $error("width must be positive");
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1_r <= '0;
      dout <= '0;
    end else begin
      stage1_r <= din;
      dout <= stage1_r;
    end
  end
endmodule

// file: design/dctd_decoder.sv
// control terminal decoder with axi4-lite registers
`timescale 1ns/1ps
`include "dctd_regs.svh"

// Operation
// - terminal-function code picks meaning of four terminals; access code picks source
// - clockwise frequency is positive, counterclockwise is negated
// - access and function both zero: terminals drive run and setpoint
// - module mode switch used only while access code is zero
// - direction modes: terminal one runs clockwise, terminal two counterclockwise
// - both direction inputs high switches the output off
// - preset one input high selects first preset, ignoring analog reference
// - two select bits choose one of four presets, bit0 low order
// - up/down inputs move digital reference within min and max limits
// - start/direction modes: start enables, direction high means counterclockwise
// - removing drive enable makes the motor coast
// - external fault input low trips the drive
// - manual override forces terminal control over fieldbus
// - analog 0 to 10 V maps linearly onto 0 to rated frequency
// - access code 0 terminals, 1/2 keypad, 3 and above fieldbus
module dctd_decoder import dctd_pkg::*; #(
  parameter int STEP_CYC = `DCTD_STEP_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire dctd_pins_t pins,
  input wire logic [11:0] analogRef,
  input wire logic [15:0] keyFreq,
  input wire logic [1:0] keyCmd,
  input wire logic [15:0] busFreq,
  input wire logic [1:0] busCmd,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output dctd_cmd_t cmd_r,
  output dctd_freq_t freq_r,
  output logic irq_r
);
  initial begin
    if (STEP_CYC < 1) begin
      $error("step count must be at least one");
    end
  end

  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  dctd_pins_t pinsS;
  dctd_sync #(.WIDTH($bits(dctd_pins_t))) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din(pins),
    .dout(pinsS)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // ctrl: [3:0] access code, [7:4] terminal function, [31:16] rated freq
  logic [31:0] ctrlReg_r;
  logic [31:0] preset01_r;
  logic [31:0] preset23_r;
  logic [31:0] limits_r;
  logic [3:0] irqStat_r;
  logic [3:0] irqMask_r;
  logic [15:0] digRef_r;
  logic [31:0] stepCnt_r;

  wire [3:0] accessCode = ctrlReg_r[3:0];
  wire [3:0] fnParam = ctrlReg_r[7:4];
  wire [15:0] ratedFreq = ctrlReg_r[31:16];
  wire [15:0] fMin = limits_r[15:0];
  wire [15:0] fMax = limits_r[31:16];

  // ----------------------------------------
  // source and mode selection
  // ----------------------------------------
  wire termAccess = (accessCode == 4'h0);
  wire [3:0] mode = (termAccess && pinsS.modPresent) ? pinsS.modSwitch : fnParam;
  wire dctd_src_t src = (pinsS.override || termAccess) ? DCTD_SRC_TERM :
                        (accessCode == 4'h1) ? DCTD_SRC_KEY1 :
                        (accessCode == 4'h2) ? DCTD_SRC_KEY2 : DCTD_SRC_BUS;

  // terminal meaning per mode; modes 0..3 defined, others act as mode 0 with terminal three ignored
  wire runClockwise = pinsS.term[0];
  wire runCounterclockwise = pinsS.term[1];
  wire terminalInputThree = pinsS.term[2];
  wire terminalInputFour = pinsS.term[3];
  // mode 0: fwd, rev, preset one, analog; 1: fwd, rev, sel0, sel1;
  // mode 2: start, dir, up, down; 3: start, dir, enable, preset one
  wire dirMode = (mode != 4'h2) && (mode != 4'h3);
  wire enaAssigned = (mode == 4'h3);
  wire driveEnableInput = enaAssigned ? terminalInputThree : 1'b1;
  wire bothDir = runClockwise && runCounterclockwise;
  wire termRunRaw = dirMode ? (runClockwise ^ runCounterclockwise) : runClockwise;
  wire termCcw = dirMode ? runCounterclockwise : runCounterclockwise;
  wire termRun = termRunRaw && driveEnableInput;
  wire presetSlotOne = (mode == 4'h0) ? terminalInputThree :
                       (mode == 4'h3) ? terminalInputFour : 1'b0;
  wire presetSelectBit0 = terminalInputThree;
  wire presetSelectBit1 = terminalInputFour;
  wire upIn = (mode == 4'h2) && terminalInputThree;
  wire downIn = (mode == 4'h2) && terminalInputFour;

  // ----------------------------------------
  // frequency reference
  // ----------------------------------------
  wire [1:0] presetIdx = {presetSelectBit1, presetSelectBit0};
  wire [15:0] presetFreq = (presetIdx == 2'd0) ? preset01_r[15:0] :
                           (presetIdx == 2'd1) ? preset01_r[31:16] :
                           (presetIdx == 2'd2) ? preset23_r[15:0] : preset23_r[31:16];
  // linear 12-bit analog scale, full code is 10 V; the top bit is folded back in so that
  // full code reaches rated frequency exactly instead of one step short
  wire [12:0] analogCode = {1'b0, analogRef} + {12'h000, analogRef[11]};
  wire [28:0] analogProd = {16'h0000, analogCode} * {13'h0000, ratedFreq};
  wire [15:0] analogFreq = analogProd[27:12];
  wire [15:0] termMag = (mode == 4'h1) ? presetFreq :
                        presetSlotOne ? preset01_r[15:0] :
                        (mode == 4'h2) ? digRef_r : analogFreq;
  wire stepTick = (stepCnt_r >= STEP_CYC - 1);
  wire [15:0] digUp = (digRef_r >= fMax) ? fMax : digRef_r + 16'h0001;
  wire [15:0] digDown = (digRef_r <= fMin) ? fMin : digRef_r - 16'h0001;
  wire [15:0] digRef_nxt = (digRef_r > fMax) ? fMax : (digRef_r < fMin) ? fMin :
                           (stepTick && upIn && !downIn) ? digUp :
                           (stepTick && downIn && !upIn) ? digDown : digRef_r;

  // ----------------------------------------
  // command selection
  // ----------------------------------------
  wire selRun = (src == DCTD_SRC_TERM) ? termRun :
                (src == DCTD_SRC_BUS) ? busCmd[0] : keyCmd[0];
  wire selCcw = (src == DCTD_SRC_TERM) ? termCcw :
                (src == DCTD_SRC_BUS) ? busCmd[1] :
                (src == DCTD_SRC_KEY2) ? keyCmd[1] : 1'b0;
  wire [15:0] selMag = (src == DCTD_SRC_TERM) ? termMag :
                       (src == DCTD_SRC_BUS) ? busFreq : keyFreq;
  wire tripNow = !pinsS.extFault;
  wire coastNow = enaAssigned && (src == DCTD_SRC_TERM) && !driveEnableInput;
  wire interlockNow = dirMode && (src == DCTD_SRC_TERM) && bothDir;
  dctd_cmd_t cmd_nxt;
  assign cmd_nxt.run = selRun && !tripNow && !coastNow && !interlockNow;
  assign cmd_nxt.ccw = selCcw;
  assign cmd_nxt.coast = coastNow || tripNow || interlockNow;
  assign cmd_nxt.trip = tripNow;
  wire dctd_freq_t freq_nxt = !cmd_nxt.run ? 16'sh0000 :
                              selCcw ? -$signed(selMag) : $signed(selMag);

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic [7:0] awAddr_r;
  logic awHeld_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic wHeld_r;
  wire doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  wire wrCtrl = doWrite && (awAddr_r == `DCTD_OFF_CTRL);
  wire wrP01 = doWrite && (awAddr_r == `DCTD_OFF_PRESET01);
  wire wrP23 = doWrite && (awAddr_r == `DCTD_OFF_PRESET23);
  wire wrLim = doWrite && (awAddr_r == `DCTD_OFF_LIMITS);
  wire wrIrqS = doWrite && (awAddr_r == `DCTD_OFF_IRQSTAT);
  wire wrIrqM = doWrite && (awAddr_r == `DCTD_OFF_IRQMASK);
  wire wrHit = wrCtrl || wrP01 || wrP23 || wrLim || wrIrqS || wrIrqM;
  wire [31:0] strbMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction
  wire [7:0] ra = s_axi_araddr[7:0];
  wire [31:0] statusWord = {24'h000000, src, mode, 1'b0, cmd_r.run};
  wire rdHit = (ra <= `DCTD_OFF_REFIN) && (ra[1:0] == 2'b00);
  wire [31:0] rdMux = (ra == `DCTD_OFF_CTRL) ? ctrlReg_r :
                      (ra == `DCTD_OFF_PRESET01) ? preset01_r :
                      (ra == `DCTD_OFF_PRESET23) ? preset23_r :
                      (ra == `DCTD_OFF_LIMITS) ? limits_r :
                      (ra == `DCTD_OFF_STATUS) ? statusWord :
                      (ra == `DCTD_OFF_FREQ) ? {{16{freq_r[15]}}, freq_r} :
                      (ra == `DCTD_OFF_IRQSTAT) ? {28'h0000000, irqStat_r} :
                      (ra == `DCTD_OFF_IRQMASK) ? {28'h0000000, irqMask_r} :
                      {16'h0000, digRef_r};
  wire doRead = s_axi_arvalid && s_axi_arready;

  // ----------------------------------------
  // interrupt events
  // ----------------------------------------
  logic runPrev_r;
  wire [3:0] irqEvt;
  assign irqEvt[`DCTD_IRQ_TRIP] = tripNow;
  assign irqEvt[`DCTD_IRQ_INTERLOCK] = interlockNow;
  assign irqEvt[`DCTD_IRQ_RUNCHG] = cmd_r.run != runPrev_r;
  assign irqEvt[`DCTD_IRQ_OVERRIDE] = pinsS.override && !termAccess;
  // set wins over the write-one clear
  wire [3:0] irqStat_nxt = (irqStat_r & ~(wrIrqS ? wStrb_r[0] ? wData_r[3:0] : 4'h0 : 4'h0))
                           | irqEvt;

  always_ff @(posedge mclk) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdHit ? rdMux : 32'h0000_0000;
        s_axi_rresp <= rdHit ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrlReg_r <= `DCTD_RST_CTRL;
      preset01_r <= `DCTD_RST_PRESET01;
      preset23_r <= `DCTD_RST_PRESET23;
      limits_r <= `DCTD_RST_LIMITS;
      irqMask_r <= 4'h0;
    end else begin
      if (wrCtrl) ctrlReg_r <= merge(ctrlReg_r, wData_r, strbMask);
      if (wrP01) preset01_r <= merge(preset01_r, wData_r, strbMask);
      if (wrP23) preset23_r <= merge(preset23_r, wData_r, strbMask);
      if (wrLim) limits_r <= merge(limits_r, wData_r, strbMask);
      if (wrIrqM && wStrb_r[0]) irqMask_r <= wData_r[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      digRef_r <= 16'h0000;
      stepCnt_r <= 32'h0000_0000;
      cmd_r <= '0;
      freq_r <= 16'sh0000;
      runPrev_r <= 1'b0;
      irqStat_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      digRef_r <= digRef_nxt;
      stepCnt_r <= stepTick ? 32'h0000_0000 : stepCnt_r + 32'h0000_0001;
      cmd_r <= cmd_nxt;
      freq_r <= freq_nxt;
      runPrev_r <= cmd_r.run;
      irqStat_r <= irqStat_nxt;
      irq_r <= |(irqStat_nxt & irqMask_r);
    end
  end
endmodule

// file: dv/dctd_term_model.sv
// terminal side model: switches or plc levels presented to the decoder pins
`timescale 1ns/1ps
module dctd_term_model import dctd_pkg::*; (
  input wire logic mclk,
  input wire logic [3:0] termSet,
  input wire logic faultSet,
  input wire logic ovrSet,
  input wire logic [3:0] swSet,
  input wire logic swFit,
  output dctd_pins_t pins
);
  // levels change once per clock, like a plc output card
  always_ff @(posedge mclk) begin
    pins.term <= termSet;
    pins.extFault <= !faultSet;
    pins.override <= ovrSet;
    pins.modSwitch <= swSet;
    pins.modPresent <= swFit;
  end
endmodule

// file: dv/dctd_decoder_checker.sv
// port-level assertions for the terminal decoder
`timescale 1ns/1ps
module dctd_decoder_checker import dctd_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire dctd_pins_t pins,
  input wire dctd_cmd_t cmd_r,
  input wire dctd_freq_t freq_r,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // sync flops are cleared by reset, so fault history is only trusted once it has flushed
  logic [3:0] rstHist_r;
  always_ff @(posedge mclk) begin
    rstHist_r <= {rstHist_r[2:0], rst};
  end
  sequence s_rtake; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_rans; s_axi_rvalid; endsequence
  property p_trip; (rstHist_r == 4'h0) && !$past(pins.extFault, 3) |-> cmd_r.trip; endproperty
  property p_tripoff; cmd_r.trip |-> !cmd_r.run; endproperty
  property p_coast; cmd_r.coast |-> !cmd_r.run; endproperty
  property p_stopzero; !cmd_r.run |-> freq_r == 16'sh0000; endproperty
  property p_ccw; cmd_r.run && cmd_r.ccw |-> freq_r <= 16'sh0000; endproperty
  property p_cw; cmd_r.run && !cmd_r.ccw |-> freq_r >= 16'sh0000; endproperty
  property p_awpulse; s_axi_awready |=> !s_axi_awready; endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_rd; s_rtake |=> s_rans; endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_trip: assert property (p_trip) else $error("trip missing with fault low");
  a_tripoff: assert property (p_tripoff) else $error("running while tripped");
  a_coast: assert property (p_coast) else $error("running while coasting");
  a_stopzero: assert property (p_stopzero) else $error("frequency while stopped");
  a_ccw: assert property (p_ccw) else $error("ccw frequency not negative");
  a_cw: assert property (p_cw) else $error("cw frequency negative");
  a_awpulse: assert property (p_awpulse) else $error("awready longer than a pulse");
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
  a_rd: assert property (p_rd) else $error("read answer late");
  a_rhold: assert property (p_rhold) else $error("read data not held");
endmodule
bind dctd_decoder dctd_decoder_checker chk_u (.mclk(mclk), .rst(rst), .pins(pins),
  .cmd_r(cmd_r), .freq_r(freq_r), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// file: dv/dctd_decoder_test.sv
// self-checking bench for the terminal decoder
`timescale 1ns/1ps
`include "dctd_regs.svh"
module dctd_decoder_test import dctd_pkg::*; ;
  logic mclk = 1'b0, rst = 1'b1, faultSet = 1'b0, ovrSet = 1'b0, swFit = 1'b0;
  logic [3:0] termSet = 4'h0, swSet = 4'h0, s_axi_wstrb = 4'hf;
  logic [11:0] analogRef = 12'h000;
  logic [15:0] keyFreq = 16'h0000, busFreq = 16'h0000;
  logic [1:0] keyCmd = 2'h0, busCmd = 2'h0, s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  dctd_pins_t pins;
  dctd_cmd_t cmd;
  dctd_freq_t freq;
  logic [15:0] presetVal [4] = '{16'h00c8, 16'h012c, 16'h0190, 16'h01f4};
  int err_count = 0, compares = 0;
  always #4 mclk = ~mclk;
  dctd_term_model tm_u (.mclk(mclk), .termSet(termSet), .faultSet(faultSet), .ovrSet(ovrSet),
    .swSet(swSet), .swFit(swFit), .pins(pins));
  // a short up/down step keeps the clamp scenarios within a few thousand cycles
  dctd_decoder #(.STEP_CYC(4)) dut_u (.mclk(mclk), .rst(rst), .pins(pins),
    .analogRef(analogRef), .keyFreq(keyFreq), .keyCmd(keyCmd), .busFreq(busFreq),
    .busCmd(busCmd), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cmd_r(cmd), .freq_r(freq), .irq_r(irq));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task complete_run;
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task fq(input logic [15:0] e);
    chk({16'h0, freq}, {16'h0, e});
  endtask
  task settle;
    repeat (8) @(posedge mclk);
  endtask
  // ----------------------------------------
  // axi4-lite master
  // ----------------------------------------
  task axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200) begin
      err_count++;
      complete_run;
    end
  endtask
  task axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 200) begin
      err_count++;
      complete_run;
    end
  endtask
  task ctl(input logic [3:0] acc, input logic [3:0] md);
    axw(`DCTD_OFF_CTRL, {16'h01f4, 8'h00, md, acc}, rs);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    axr(`DCTD_OFF_PRESET01, rd, rs);
    chk(rd, `DCTD_RST_PRESET01);
    axr(`DCTD_OFF_PRESET23, rd, rs);
    chk(rd, `DCTD_RST_PRESET23);
    axr(32'h40, rd, rs);
    chk({30'h0, rs}, 32'h2);
    axw(`DCTD_OFF_STATUS, 32'hff, rs);
    chk({30'h0, rs}, 32'h2);
    ctl(4'h0, 4'h0);
    termSet <= 4'h5;
    settle;
    fq(16'h00c8);
    chk({28'h0, cmd}, 32'h8);
    termSet <= 4'h6;
    settle;
    fq(16'hff38);
    termSet <= 4'h3;
    settle;
    chk({31'h0, cmd.run}, 32'h0);
    axr(`DCTD_OFF_IRQSTAT, rd, rs);
    chk(rd & 32'h2, 32'h2);
    axw(`DCTD_OFF_IRQMASK, 32'h2, rs);
    settle;
    chk({31'h0, irq}, 32'h1);
    termSet <= 4'h1;
    settle;
    axw(`DCTD_OFF_IRQSTAT, 32'h2, rs);
    settle;
    chk({31'h0, irq}, 32'h0);
    analogRef <= 12'hfff;
    settle;
    fq(16'h01f4);
    analogRef <= 12'h000;
    settle;
    fq(16'h0000);
    faultSet <= 1'b1;
    settle;
    chk({30'h0, cmd.run, cmd.trip}, 32'h1);
    faultSet <= 1'b0;
    ctl(4'h0, 4'h1);
    for (int i = 0; i < 4; i++) begin
      termSet <= {i[1:0], 2'b01};
      settle;
      fq(presetVal[i]);
    end
    ctl(4'h0, 4'h0);
    swFit <= 1'b1;
    swSet <= 4'h1;
    termSet <= 4'h5;
    settle;
    fq(16'h012c);
    ctl(4'h3, 4'h0);
    busCmd <= 2'h1;
    busFreq <= 16'h0096;
    settle;
    fq(16'h0096);
    ovrSet <= 1'b1;
    settle;
    fq(16'h00c8);
    ovrSet <= 1'b0;
    swFit <= 1'b0;
    keyCmd <= 2'h3;
    keyFreq <= 16'h0064;
    ctl(4'h1, 4'h0);
    settle;
    fq(16'h0064);
    ctl(4'h2, 4'h0);
    settle;
    fq(16'hff9c);
    ctl(4'h0, 4'h2);
    termSet <= 4'h7;
    repeat (2500) @(posedge mclk);
    fq(16'hfe0c);
    termSet <= 4'h9;
    repeat (2500) @(posedge mclk);
    chk({31'h0, cmd.ccw}, 32'h0);
    fq(16'h0000);
    ctl(4'h0, 4'h3);
    termSet <= 4'h1;
    settle;
    chk({30'h0, cmd.run, cmd.coast}, 32'h1);
    termSet <= 4'h5;
    settle;
    chk({31'h0, cmd.run}, 32'h1);
    complete_run;
  end
endmodule
